// >>> hdl/epco_exec.sv
`timescale 1ns/10ps
module epco_exec (
  input  wire logic               clock,
  input  wire logic               reset_n,
  input  wire logic               clk_en,
  input  wire logic               extended_set_config_bit,
  input  wire logic               instr_valid,
  input  wire logic [15:0]        instr_word,
  input  wire epco_pkg::epco_core_s core_in,
  output epco_pkg::epco_exec_s    exec_out
);

  logic [1:0]                 phase_ff;
  logic [1:0]                 nxt_phase;
  epco_pkg::epco_state_e      state_ff;
  epco_pkg::epco_state_e      nxt_state;
  epco_pkg::epco_op_e         op_ff;
  epco_pkg::epco_op_e         nxt_op;
  logic [epco_pkg::LIT_W-1:0] lit_ff;
  logic [epco_pkg::LIT_W-1:0] nxt_lit;
  logic [1:0]                 sel_ff;
  logic [1:0]                 nxt_sel;
  epco_pkg::epco_exec_s       out_ff;
  epco_pkg::epco_exec_s       nxt_out;
  logic [epco_pkg::PTR_W-1:0] sel_ptr;
  epco_pkg::epco_op_e         dec_op;

  assign exec_out = out_ff;

  // The enable bit gates recognition so standard-set code never sees these opcodes.
  always_comb begin
    dec_op = epco_pkg::OP_NONE;
    if (extended_set_config_bit) begin
      if (instr_word[15:8] == epco_pkg::PADD_UPPER) begin
        if (instr_word[7:6] == epco_pkg::SEL_RETURN) begin
          dec_op = epco_pkg::OP_PRET;
        end else begin
          dec_op = epco_pkg::OP_PADD;
        end
      end else if (instr_word == epco_pkg::CALL_VIA_WORKING_REG_OPCODE) begin
        dec_op = epco_pkg::OP_CALL_VIA_WORKING_REG;
      end
    end
  end

  always_comb begin
    case (sel_ff)
      2'h0:    sel_ptr = core_in.ptr0;
      2'h1:    sel_ptr = core_in.ptr1;
      default: sel_ptr = core_in.ptr2;
    endcase
  end

  always_comb begin
    nxt_phase = phase_ff;
    nxt_state = state_ff;
    nxt_op    = op_ff;
    nxt_lit   = lit_ff;
    nxt_sel   = sel_ff;
    nxt_out   = out_ff;
    if (clk_en) begin
      nxt_phase          = phase_ff + 2'h1;
      nxt_out.ptr_we     = 1'b0;
      nxt_out.push       = 1'b0;
      nxt_out.pop        = 1'b0;
      nxt_out.pc_load    = 1'b0;
      case (state_ff)
        epco_pkg::ST_NORMAL: begin
          if (phase_ff == epco_pkg::PH_Q1) begin
            // Instructions are only taken at the start of a normal cycle.
            nxt_op          = instr_valid ? dec_op : epco_pkg::OP_NONE;
            nxt_lit         = instr_word[epco_pkg::LIT_W-1:0];
            nxt_sel         = instr_word[7:6];
            nxt_out.claimed = instr_valid && (dec_op != epco_pkg::OP_NONE);
          end else if (phase_ff == epco_pkg::PH_Q3) begin
            if (op_ff == epco_pkg::OP_CALL_VIA_WORKING_REG) begin
              nxt_out.push       = 1'b1;
              nxt_out.push_value = core_in.pc + epco_pkg::RET_STEP;
            end
          end else if (phase_ff == epco_pkg::PH_Q4) begin
            nxt_out.claimed = 1'b0;
            nxt_op          = epco_pkg::OP_NONE;
            case (op_ff)
              epco_pkg::OP_PADD: begin
                // Sum wraps at the pointer width; no status flag is touched.
                nxt_out.ptr_we    = 1'b1;
                nxt_out.ptr_sel   = sel_ff;
                nxt_out.ptr_value = sel_ptr + {{(epco_pkg::PTR_W-epco_pkg::LIT_W){1'b0}},
                                               lit_ff};
              end
              epco_pkg::OP_PRET: begin
                nxt_out.ptr_we    = 1'b1;
                nxt_out.ptr_sel   = epco_pkg::SEL_PTR_TWO;
                nxt_out.ptr_value = core_in.ptr2 + {{(epco_pkg::PTR_W-epco_pkg::LIT_W){1'b0}},
                                                    lit_ff};
                nxt_out.pop       = 1'b1;
                nxt_out.pc_load   = 1'b1;
                nxt_out.pc_value  = core_in.return_stack_top;
                nxt_out.nop_cycle = 1'b1;
                nxt_state         = epco_pkg::ST_NOP;
              end
              epco_pkg::OP_CALL_VIA_WORKING_REG: begin
                // Only the PC changes; working, status and bank registers stay put.
                nxt_out.pc_load   = 1'b1;
                nxt_out.pc_value  = {core_in.pc_upper_latch, core_in.pc_high_latch,
                                     core_in.working_reg};
                nxt_out.nop_cycle = 1'b1;
                nxt_state         = epco_pkg::ST_NOP;
              end
              default: begin
                nxt_out.ptr_we = 1'b0;
              end
            endcase
          end
        end
        epco_pkg::ST_NOP: begin
          // Second cycle does nothing while the new target is fetched.
          if (phase_ff == epco_pkg::PH_Q4) begin
            nxt_out.nop_cycle = 1'b0;
            nxt_state         = epco_pkg::ST_NORMAL;
          end
        end
        default: begin
          nxt_state = epco_pkg::ST_NORMAL;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      phase_ff <= epco_pkg::PH_Q1;
      state_ff <= epco_pkg::ST_NORMAL;
      op_ff    <= epco_pkg::OP_NONE;
      lit_ff   <= '0;
      sel_ff   <= '0;
      out_ff   <= epco_pkg::EXEC_IDLE;
    end else begin
      phase_ff <= nxt_phase;
      state_ff <= nxt_state;
      op_ff    <= nxt_op;
      lit_ff   <= nxt_lit;
      sel_ff   <= nxt_sel;
      out_ff   <= nxt_out;
    end
  end

endmodule

// >>> hdl/epco_pkg.sv
// Function
// - Extended opcodes are decoded and run only if the extension enable bit is set when the word is taken.
// - Pointer add matches upper byte 1110 1000; select in 7:6; literal 5:0; no flags.
// - Pointer add sums unsigned 6-bit literal into chosen pointer 0 to 2, writes back.
// - Select value 11 means add-and-return, always working on pointer two.
// - Add-and-return sums the unsigned 6-bit literal into pointer two.
// - After adding, add-and-return pops the stack and loads PC from its top.
// - Add-and-return takes two cycles; the second is a pipeline-refill no-operation.
// - Call via working register first pushes PC plus 2 onto the return stack.
// - Call via working register then copies the working register into the PC low byte.
// - Then PC high and upper bytes load from the high and upper latches.
// - Call via working register takes two cycles; the second is a no-operation fetch.
// - Call via working register saves and restores no working, status or bank register.
package epco_pkg;

  localparam int PTR_W = 12;
  localparam int PC_W  = 21;
  localparam int LIT_W = 6;

  localparam logic [7:0]  PADD_UPPER   = 8'hE8;
  localparam logic [1:0]  SEL_RETURN   = 2'h3;
  localparam logic [1:0]  SEL_PTR_TWO  = 2'h2;
  localparam logic [15:0] CALL_VIA_WORKING_REG_OPCODE = 16'h0014;
  localparam logic [PC_W-1:0] RET_STEP = 21'h000002;

  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;

  typedef enum logic [0:0] {
    ST_NORMAL = 1'b0,
    ST_NOP    = 1'b1
  } epco_state_e;

  typedef enum logic [1:0] {
    OP_NONE  = 2'b00,
    OP_PADD  = 2'b01,
    OP_PRET  = 2'b10,
    OP_CALL_VIA_WORKING_REG = 2'b11
  } epco_op_e;

  typedef struct packed {
    logic [PTR_W-1:0] ptr0;
    logic [PTR_W-1:0] ptr1;
    logic [PTR_W-1:0] ptr2;
    logic [PC_W-1:0]  pc;
    logic [PC_W-1:0]  return_stack_top;
    logic [7:0]       working_reg;
    logic [7:0]       pc_high_latch;
    logic [4:0]       pc_upper_latch;
  } epco_core_s;

  typedef struct packed {
    logic             claimed;
    logic             nop_cycle;
    logic             ptr_we;
    logic [1:0]       ptr_sel;
    logic [PTR_W-1:0] ptr_value;
    logic             push;
    logic [PC_W-1:0]  push_value;
    logic             pop;
    logic             pc_load;
    logic [PC_W-1:0]  pc_value;
  } epco_exec_s;

  localparam epco_exec_s EXEC_IDLE = '0;

endpackage

// >>> tb/epco_exec_bench.sv
`timescale 1ns/10ps
module epco_exec_bench;
  logic                 clock = 1'b0;
  logic                 reset_n = 1'b0;
  logic                 ext = 1'b1;
  logic                 valid = 1'b0;
  logic [15:0]          word = 16'h0000;
  epco_pkg::epco_core_s c;
  epco_pkg::epco_exec_s o;
  logic [20:0]          pv;
  logic                 cl;
  int                   errors = 0;
  int                   comparisons = 0;
  int                   cycles = 0;
  epco_exec i_epco_exec (.clock(clock), .reset_n(reset_n), .clk_en(1'b1),
    .extended_set_config_bit(ext), .instr_valid(valid), .instr_word(word), .core_in(c),
    .exec_out(o));
  always #10 clock = ~clock;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic finish_test;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 400) begin
      errors++;
      finish_test;
    end
  end
  // Returns just after the Q4 edge, so the next call lands on the following Q1.
  task automatic op(input logic [15:0] w);
    valid = 1'b1;
    word = w;
    @(posedge clock);
    #1 valid = 1'b0;
    repeat (2) @(posedge clock);
    #1 pv = o.push ? o.push_value : 21'h1FFFFF;
    cl = o.claimed;
    @(posedge clock);
    #1;
  endtask
  task automatic t_off;
    ext = 1'b0;
    op(16'hE845);
    chk({cl, o.ptr_we, pv}, 23'h1FFFFF);
    op(16'h0014);
    chk({cl, o.pc_load, pv}, 23'h1FFFFF);
    ext = 1'b1;
    op(16'hE945);
    chk({cl, o.ptr_we}, 0);
  endtask
  task automatic t_padd;
    for (int s = 0; s < 3; s++) begin
      op({8'hE8, s[1:0], 6'h3F});
      chk({cl, o.ptr_we, o.ptr_sel}, 4'hC | s);
      chk(o.ptr_value, s == 0 ? 12'h000 : 12'h43E);
      chk({o.pop, o.pc_load, o.nop_cycle, pv}, 24'h1FFFFF);
    end
  endtask
  task automatic t_pret;
    op(16'hE8E3);
    chk({o.ptr_we, o.ptr_sel, o.ptr_value}, 15'h6422);
    chk({o.pop, o.pc_load, o.nop_cycle, o.pc_value}, 24'hEABCDE);
    repeat (4) @(posedge clock);
    #1 chk(o.nop_cycle, 0);
  endtask
  task automatic t_call;
    op(16'h0014);
    chk(pv, 21'h000102);
    chk({o.push, o.pc_load, o.nop_cycle, o.ptr_we, o.pop}, 5'h0C);
    chk(o.pc_value, 21'h0A1006);
    repeat (4) @(posedge clock);
    #1 chk(o.nop_cycle, 0);
  endtask
  initial begin
    c = '0;
    c.ptr0 = 12'hFC1;
    c.ptr1 = 12'h3FF;
    c.ptr2 = 12'h3FF;
    c.pc = 21'h000100;
    c.return_stack_top = 21'h0ABCDE;
    c.working_reg = 8'h06;
    c.pc_high_latch = 8'h10;
    c.pc_upper_latch = 5'h0A;
    repeat (6) @(posedge clock);
    #1 reset_n = 1'b1;
    t_off;
    t_padd;
    t_pret;
    t_call;
    finish_test;
  end
endmodule

// >>> tb/epco_exec_monitor.sv
`timescale 1ns/10ps
module epco_exec_monitor (
  input wire logic                 clock,
  input wire logic                 reset_n,
  input wire logic                 clk_en,
  input wire logic                 extended_set_config_bit,
  input wire logic                 instr_valid,
  input wire logic [15:0]          instr_word,
  input wire epco_pkg::epco_core_s core_in,
  input wire epco_pkg::epco_exec_s exec_out
);
  // The word is judged one edge after the take, so clk_en must stay high for these.
  wire padd = instr_word[15:8] == 8'hE8 && instr_word[7:6] != 2'h3;
  wire pret = instr_word[15:6] == 10'h3A3;
  wire call = instr_word == 16'h0014;
  wire up   = exec_out.claimed;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  AST_ENABLE: assert property ($rose(up) |-> $past(extended_set_config_bit && instr_valid))
    else $error("op claimed without enable");
  AST_PADD: assert property ($rose(up) && $past(padd) |-> ##3 exec_out.ptr_we &&
    exec_out.ptr_sel == $past(instr_word[7:6], 4) && !exec_out.pc_load && !exec_out.nop_cycle)
    else $error("pointer add write wrong");
  AST_PULSE: assert property (exec_out.ptr_we |=> !exec_out.ptr_we)
    else $error("pointer write too long");
  AST_PRET_SUM: assert property ($rose(up) && $past(pret) |-> ##3 exec_out.ptr_sel == 2'h2 &&
    exec_out.ptr_value == $past(core_in.ptr2) + $past(instr_word[5:0], 4))
    else $error("add-and-return sum wrong");
  AST_PRET_RET: assert property ($rose(up) && $past(pret) |-> ##3 exec_out.pop &&
    exec_out.pc_load && exec_out.pc_value == $past(core_in.return_stack_top))
    else $error("add-and-return no return");
  AST_CALL: assert property ($rose(up) && $past(call) |-> ##2 exec_out.push &&
    exec_out.push_value == $past(core_in.pc) + 21'h2 ##1 !exec_out.push && exec_out.pc_load &&
    exec_out.pc_value == {core_in.pc_upper_latch, core_in.pc_high_latch, core_in.working_reg})
    else $error("call via W wrong");
  AST_NOP: assert property ($rose(up) && $past(pret || call) |->
    ##3 exec_out.nop_cycle [*4] ##1 !exec_out.nop_cycle)
    else $error("no-op cycle wrong");
  AST_POP: assert property (exec_out.pop |-> exec_out.pc_load && exec_out.ptr_sel == 2'h2)
    else $error("pop without pointer two");
endmodule
bind epco_exec epco_exec_monitor i_epco_exec_monitor (.clock(clock), .reset_n(reset_n),
  .clk_en(clk_en), .extended_set_config_bit(extended_set_config_bit),
  .instr_valid(instr_valid), .instr_word(instr_word), .core_in(core_in), .exec_out(exec_out));
